// ==== src/amcs_regs.vh ====
`ifndef AMCS_REGS_VH
`define AMCS_REGS_VH
// Register byte offsets on the Avalon-MM slave
`define AMCS_OFS_RUN_MODE_WORD 6'h00
`define AMCS_OFS_RUN_COMMAND_WORD 6'h04
`define AMCS_OFS_MOTION_COMMAND_CODE 6'h08
`define AMCS_OFS_COMMAND_CONTROL_WORD 6'h0c
`define AMCS_OFS_TRAVERSE_SPEED_LONG 6'h10
`define AMCS_OFS_TRAVERSE_SPEED_WORD 6'h14
`define AMCS_OFS_STEP_DISTANCE 6'h18
`define AMCS_OFS_POSITION_REFERENCE 6'h1c
`define AMCS_OFS_IN_POSITION_WIDTH 6'h20
`define AMCS_OFS_FIXED_PARAM_13 6'h24
`define AMCS_OFS_ACCEL_STEP 6'h28
`define AMCS_OFS_RUN_STATUS_WORD 6'h2c
`define AMCS_OFS_COMMAND_STATUS_WORD 6'h30
`define AMCS_OFS_COMMAND_RESPONSE_CODE 6'h34
`define AMCS_OFS_POSITION 6'h38
`define AMCS_OFS_CAPTURED_POSITION 6'h3c
// Field positions
`define AMCS_BIT_POSITION_CONTROL_MODE 2
`define AMCS_BIT_SERVO_ON 0
`define AMCS_BIT_HOLD 0
`define AMCS_BIT_ABORT 1
`define AMCS_BIT_DIRECTION 2
`define AMCS_BIT_BUSY 0
`define AMCS_BIT_HOLD_DONE 1
`define AMCS_BIT_DIST_DONE 2
`define AMCS_BIT_CAPTURE_DONE 4
`define AMCS_BIT_POSITIONING_DONE 13
// Command codes
`define AMCS_CMD_IDLE 4'h0
`define AMCS_CMD_REFERENCE_FOLLOWING_MOVE 4'h4
`define AMCS_CMD_CAPTURE_MOVE 4'h5
`define AMCS_CMD_CONSTANT_VELOCITY 4'h7
`define AMCS_CMD_FIXED_LENGTH 4'h8
// Reset values
`define AMCS_RST_IN_POSITION_WIDTH 32'h0000000a
`define AMCS_RST_ACCEL_STEP 32'h00000010
// Scan period in ns and clock period in ns
`define AMCS_SCAN_PERIOD_NS 1000
`define AMCS_CLK_PERIOD_NS 10
`define AMCS_SCAN_CYCLES (`AMCS_SCAN_PERIOD_NS / `AMCS_CLK_PERIOD_NS)
`endif

// ==== src/amcs_profile.v ====
`timescale 1ns/1ps
`include "amcs_regs.vh"
// =====================================================================
// Speed ramp: moves velocity toward a target by a fixed step each scan
module amcs_profile #(
    parameter W = 32
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_scan,
    input wire [W-1:0] i_target,
    input wire [W-1:0] i_accel,
    output reg [W-1:0] o_speed
);
    // Ramp only on scan ticks so accel is expressed per scan
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_speed <= {W{1'b0}};
        end else if (i_scan) begin
            if (o_speed + i_accel < i_target)
                o_speed <= o_speed + i_accel;
            else if (o_speed > i_target + i_accel)
                o_speed <= o_speed - i_accel;
            else
                o_speed <= i_target;
        end
    end
endmodule

// ==== src/amcs_sequencer.v ====
// Summary of operation
// - Capture latches the position counter; captured value reported in units.
// - Fixed parameter 13 picks capture source: 0 input three, 1 index.
// - Code 7 starts constant velocity move at traverse speed with ramps.
// - Constant velocity has no end point; speed changes apply live.
// - Idle code during constant velocity decelerates to a stop.
// - Hold is ignored during constant velocity moves.
// - Positioning done set once distribution done and within width.
// - Code 8 steps programmed distance in chosen direction with ramps.
// - Step distance latched at start; new value used next time.
// - Motion settings including speed may change during a step.
// - Hold bit pauses a step, then hold done is reported.
// - Clearing hold resumes the step toward remaining distance.
// - Abort bit or idle code aborts a step; stays stopped.
// - Step reaching distribution done is finished and released.
// - Step starts on command rising edge only; idle scan to repeat.
// - Reference following moves by host reference refreshed each scan.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "amcs_regs.vh"
module amcs_sequencer #(
    parameter SCAN_CYCLES = `AMCS_SCAN_CYCLES,
    parameter UNIT_SHIFT = 0
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    input wire i_external_input_three,
    input wire i_encoder_index,
    output reg [31:0] o_axis_position,
    output reg [31:0] o_axis_speed,
    output reg o_axis_enable
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_FOLLOW = 5'b00010;
    localparam ST_CONST = 5'b00100;
    localparam ST_STEP = 5'b01000;
    localparam ST_STOP = 5'b10000;

    // ==================================================================
    // Registers
    reg [31:0] run_mode_word;
    reg [31:0] run_command_word;
    reg [3:0] motion_command_code;
    reg [31:0] command_control_word;
    reg [31:0] traverse_speed_long;
    reg [15:0] traverse_speed_word;
    reg [31:0] step_distance;
    reg [31:0] position_reference;
    reg [31:0] in_position_width;
    reg fixed_param_13;
    reg [31:0] accel_step;
    reg [31:0] captured_position;
    reg [3:0] command_response_code;
    reg [4:0] state;
    reg [3:0] cmd_scan;
    reg [3:0] cmd_prev;
    reg hold_scan;
    reg abort_scan;
    reg [31:0] remaining;
    reg [31:0] target_speed;
    reg dist_done;
    reg hold_done;
    reg capture_done;
    reg capture_armed;
    reg busy;
    reg reverse;
    reg [31:0] scan_cnt;
    reg scan;
    wire [31:0] ramp_speed;
    wire [31:0] speed_setting;
    wire [31:0] err;
    wire in_width;
    wire capture_src;
    wire ready;
    wire code_edge;

    // Long word setting wins when non-zero, else the word setting
    assign speed_setting = (traverse_speed_long != 32'h0) ?
        traverse_speed_long : {16'h0, traverse_speed_word};
    assign err = (position_reference > o_axis_position) ?
        position_reference - o_axis_position :
        o_axis_position - position_reference;
    assign in_width = (err <= in_position_width);
    assign capture_src = fixed_param_13 ? i_encoder_index :
        i_external_input_three;
    assign ready = run_mode_word[`AMCS_BIT_POSITION_CONTROL_MODE] &&
        run_command_word[`AMCS_BIT_SERVO_ON];
    assign code_edge = (cmd_scan != cmd_prev);

    function amcs_hit;
        input [5:0] a;
        input [5:0] ofs;
        begin
            amcs_hit = (a == ofs);
        end
    endfunction

    // ==================================================================
    // Avalon slave: one wait cycle, then the answer
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
            run_mode_word <= 32'h0;
            run_command_word <= 32'h0;
            motion_command_code <= `AMCS_CMD_IDLE;
            command_control_word <= 32'h0;
            traverse_speed_long <= 32'h0;
            traverse_speed_word <= 16'h0;
            step_distance <= 32'h0;
            position_reference <= 32'h0;
            in_position_width <= `AMCS_RST_IN_POSITION_WIDTH;
            fixed_param_13 <= 1'b0;
            accel_step <= `AMCS_RST_ACCEL_STEP;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) &&
                o_avs_waitrequest);
            if ((i_avs_read || i_avs_write) && !o_avs_waitrequest)
                o_avs_waitrequest <= 1'b1;
            if (i_avs_write && !o_avs_waitrequest) begin
                if (amcs_hit(i_avs_address, `AMCS_OFS_RUN_MODE_WORD))
                    run_mode_word <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_RUN_COMMAND_WORD))
                    run_command_word <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_MOTION_COMMAND_CODE))
                    motion_command_code <= i_avs_writedata[3:0];
                if (amcs_hit(i_avs_address, `AMCS_OFS_COMMAND_CONTROL_WORD))
                    command_control_word <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_TRAVERSE_SPEED_LONG))
                    traverse_speed_long <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_TRAVERSE_SPEED_WORD))
                    traverse_speed_word <= i_avs_writedata[15:0];
                if (amcs_hit(i_avs_address, `AMCS_OFS_STEP_DISTANCE))
                    step_distance <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_POSITION_REFERENCE))
                    position_reference <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_IN_POSITION_WIDTH))
                    in_position_width <= i_avs_writedata;
                if (amcs_hit(i_avs_address, `AMCS_OFS_FIXED_PARAM_13))
                    fixed_param_13 <= i_avs_writedata[0];
                if (amcs_hit(i_avs_address, `AMCS_OFS_ACCEL_STEP))
                    accel_step <= i_avs_writedata;
            end
            if (i_avs_read && o_avs_waitrequest) begin
                case (i_avs_address)
                `AMCS_OFS_RUN_MODE_WORD: o_avs_readdata <= run_mode_word;
                `AMCS_OFS_RUN_COMMAND_WORD:
                    o_avs_readdata <= run_command_word;
                `AMCS_OFS_MOTION_COMMAND_CODE:
                    o_avs_readdata <= {28'h0, motion_command_code};
                `AMCS_OFS_COMMAND_CONTROL_WORD:
                    o_avs_readdata <= command_control_word;
                `AMCS_OFS_TRAVERSE_SPEED_LONG:
                    o_avs_readdata <= traverse_speed_long;
                `AMCS_OFS_TRAVERSE_SPEED_WORD:
                    o_avs_readdata <= {16'h0, traverse_speed_word};
                `AMCS_OFS_STEP_DISTANCE: o_avs_readdata <= step_distance;
                `AMCS_OFS_POSITION_REFERENCE:
                    o_avs_readdata <= position_reference;
                `AMCS_OFS_IN_POSITION_WIDTH:
                    o_avs_readdata <= in_position_width;
                `AMCS_OFS_FIXED_PARAM_13:
                    o_avs_readdata <= {31'h0, fixed_param_13};
                `AMCS_OFS_ACCEL_STEP: o_avs_readdata <= accel_step;
                `AMCS_OFS_RUN_STATUS_WORD: begin
                    o_avs_readdata <= {18'h0, dist_done && in_width,
                        10'h0, ready, 1'b0, o_axis_enable};
                end
                `AMCS_OFS_COMMAND_STATUS_WORD:
                    o_avs_readdata <= {27'h0, capture_done, 1'b0,
                        dist_done, hold_done, busy};
                `AMCS_OFS_COMMAND_RESPONSE_CODE:
                    o_avs_readdata <= {28'h0, command_response_code};
                `AMCS_OFS_POSITION: o_avs_readdata <= o_axis_position;
                `AMCS_OFS_CAPTURED_POSITION:
                    o_avs_readdata <= captured_position;
                default: o_avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ==================================================================
    // Scan timer; all motion decisions happen on the scan tick
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scan_cnt <= 32'h0;
            scan <= 1'b0;
        end else begin
            scan <= (scan_cnt == SCAN_CYCLES - 1);
            if (scan_cnt == SCAN_CYCLES - 1)
                scan_cnt <= 32'h0;
            else
                scan_cnt <= scan_cnt + 32'h1;
        end
    end

    amcs_profile #(
        .W(32)
    ) u_profile (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_scan(scan),
        .i_target(target_speed),
        .i_accel(accel_step),
        .o_speed(ramp_speed)
    );

    // ==================================================================
    // Command sequencer
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            cmd_scan <= `AMCS_CMD_IDLE;
            cmd_prev <= `AMCS_CMD_IDLE;
            hold_scan <= 1'b0;
            abort_scan <= 1'b0;
            remaining <= 32'h0;
            target_speed <= 32'h0;
            dist_done <= 1'b1;
            hold_done <= 1'b0;
            capture_done <= 1'b0;
            capture_armed <= 1'b0;
            busy <= 1'b0;
            reverse <= 1'b0;
            captured_position <= 32'h0;
            command_response_code <= `AMCS_CMD_IDLE;
            o_axis_position <= 32'h0;
            o_axis_speed <= 32'h0;
            o_axis_enable <= 1'b0;
        end else begin
            // capture is checked every clock, not only on scans
            if (capture_armed && capture_src) begin
                captured_position <= o_axis_position >>> UNIT_SHIFT;
                capture_done <= 1'b1;
                capture_armed <= 1'b0;
            end
            if (scan) begin
                cmd_scan <= motion_command_code;
                cmd_prev <= cmd_scan;
                hold_scan <= command_control_word[`AMCS_BIT_HOLD];
                abort_scan <= command_control_word[`AMCS_BIT_ABORT];
                o_axis_enable <= run_command_word[`AMCS_BIT_SERVO_ON];
                o_axis_speed <= ramp_speed;
                command_response_code <= cmd_scan;
                case (state)
                ST_IDLE: begin
                    busy <= 1'b0;
                    target_speed <= 32'h0;
                    if (ready && code_edge) begin
                        if (cmd_scan == `AMCS_CMD_FIXED_LENGTH) begin
                            remaining <= step_distance;
                            reverse <= command_control_word
                                [`AMCS_BIT_DIRECTION];
                            dist_done <= 1'b0;
                            busy <= 1'b1;
                            state <= ST_STEP;
                        end else if (cmd_scan ==
                            `AMCS_CMD_CONSTANT_VELOCITY) begin
                            reverse <= command_control_word
                                [`AMCS_BIT_DIRECTION];
                            dist_done <= 1'b0;
                            busy <= 1'b1;
                            state <= ST_CONST;
                        end
                    end
                    if (ready && (cmd_scan ==
                        `AMCS_CMD_REFERENCE_FOLLOWING_MOVE ||
                        (cmd_scan == `AMCS_CMD_CAPTURE_MOVE &&
                        code_edge))) begin
                        capture_armed <= (cmd_scan == `AMCS_CMD_CAPTURE_MOVE);
                        // new capture needs an idle scan first
                        capture_done <= 1'b0;
                        busy <= 1'b1;
                        state <= ST_FOLLOW;
                    end
                end
                ST_FOLLOW: begin
                    o_axis_position <= position_reference;
                    dist_done <= 1'b1;
                    if (cmd_scan != `AMCS_CMD_REFERENCE_FOLLOWING_MOVE &&
                        cmd_scan != `AMCS_CMD_CAPTURE_MOVE) begin
                        capture_armed <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_CONST: begin
                    // live speed, no end point; hold ignored
                    target_speed <= speed_setting;
                    o_axis_position <= reverse ?
                        o_axis_position - ramp_speed :
                        o_axis_position + ramp_speed;
                    if (cmd_scan == `AMCS_CMD_IDLE) begin
                        target_speed <= 32'h0;
                        state <= ST_STOP;
                    end
                end
                ST_STEP: begin
                    target_speed <= hold_scan ? 32'h0 : speed_setting;
                    hold_done <= hold_scan && ramp_speed == 32'h0;
                    if (ramp_speed >= remaining) begin
                        o_axis_position <= reverse ?
                            o_axis_position - remaining :
                            o_axis_position + remaining;
                        remaining <= 32'h0;
                        dist_done <= 1'b1;
                        busy <= 1'b0;
                        target_speed <= 32'h0;
                        state <= ST_IDLE;
                    end else begin
                        o_axis_position <= reverse ?
                            o_axis_position - ramp_speed :
                            o_axis_position + ramp_speed;
                        remaining <= remaining - ramp_speed;
                    end
                    if (abort_scan || cmd_scan == `AMCS_CMD_IDLE) begin
                        target_speed <= 32'h0;
                        hold_done <= 1'b0;
                        state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    o_axis_position <= reverse ?
                        o_axis_position - ramp_speed :
                        o_axis_position + ramp_speed;
                    if (ramp_speed == 32'h0) begin
                        dist_done <= 1'b1;
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== dv/amcs_servo_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// Encoder side of the servo amplifier
module amcs_servo_model (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [31:0] i_axis_position,
    output reg o_encoder_index,
    output reg [31:0] o_index_position
);
    reg [31:0] last_pos;
    // index pulse source
    // One clock of index on each 256-count boundary the axis crosses
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_pos <= 32'h0;
            o_encoder_index <= 1'b0;
            o_index_position <= 32'h0;
        end else begin
            last_pos <= i_axis_position;
            o_encoder_index <= i_axis_position[31:8] != last_pos[31:8];
            if (i_axis_position[31:8] != last_pos[31:8]) begin
                o_index_position <= i_axis_position;
            end
        end
    end
endmodule

// ==== dv/amcs_monitor.sv ====
`timescale 1ns/1ps
// =====================================================================
// Port checker for the axis command sequencer
module amcs_monitor #(
    parameter SCAN_CYCLES = 4
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire i_external_input_three,
    input wire i_encoder_index,
    input wire [31:0] o_axis_position,
    input wire [31:0] o_axis_speed,
    input wire o_axis_enable
);
    logic [31:0] spd_w, step_w, acc_w;
    logic servo_w;
    int since;
    wire req = i_avs_read || i_avs_write;
    wire rd_take = i_avs_read && o_avs_waitrequest;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadow of host writes at completion
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            spd_w <= 32'h0;
            step_w <= 32'h0;
            acc_w <= 32'h10;
            servo_w <= 1'b0;
        end else if (i_avs_write && !o_avs_waitrequest) begin
            case (i_avs_address)
                6'h04: servo_w <= i_avs_writedata[0];
                6'h10: spd_w <= i_avs_writedata;
                6'h18: step_w <= i_avs_writedata;
                6'h28: acc_w <= i_avs_writedata;
                default: ;
            endcase
        end
    end
    // Cycles since the speed last moved
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) since <= SCAN_CYCLES;
        else if ($changed(o_axis_speed)) since <= 0;
        else if (since < SCAN_CYCLES) since <= since + 1;
    end
    a_answer_next: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    a_unmapped_zero: assert property (rd_take && i_avs_address[1:0] != 2'h0 |=> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_resp_legal: assert property (rd_take && i_avs_address == 6'h34 |=> o_avs_readdata inside {32'h0, 32'h4, 32'h5, 32'h7, 32'h8})
        else $error("bad response code");
    a_speed_kept: assert property (rd_take && i_avs_address == 6'h10 |=> o_avs_readdata == spd_w)
        else $error("speed setting lost");
    a_step_kept: assert property (rd_take && i_avs_address == 6'h18 |=> o_avs_readdata == step_w)
        else $error("step distance lost");
    a_ramp_bound: assert property ($changed(o_axis_speed) |-> (o_axis_speed - $past(o_axis_speed) <= acc_w) || ($past(o_axis_speed) - o_axis_speed <= acc_w))
        else $error("speed step too big");
    a_scan_paced: assert property ($changed(o_axis_speed) |-> since >= SCAN_CYCLES - 1)
        else $error("speed changed mid scan");
    a_enable_follow: assert property ($changed(servo_w) |-> ##[1:16] o_axis_enable == servo_w)
        else $error("servo enable not applied");
    c_feed: cover property (i_avs_write && i_avs_address == 6'h08 && i_avs_writedata == 32'h7);
    c_step: cover property (i_avs_write && i_avs_address == 6'h08 && i_avs_writedata == 32'h8);
    c_index: cover property (i_encoder_index);
endmodule
bind amcs_sequencer amcs_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) amcs_monitor_inst (
    .i_core_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
    .i_external_input_three, .i_encoder_index, .o_axis_position,
    .o_axis_speed, .o_axis_enable);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
// =====================================================================
// Bench for the axis command sequencer
module tb_top;
    localparam int SCAN = 4;
    logic i_core_clk, i_rst_b, i_avs_read, i_avs_write, external_input_three;
    logic [5:0] i_avs_address;
    logic [31:0] i_avs_writedata, q, p0;
    wire [31:0] o_avs_readdata, o_axis_position, o_axis_speed, idx_pos;
    wire o_avs_waitrequest, o_axis_enable, enc_index;
    int err_count = 0;
    int comparisons = 0;
    amcs_sequencer #(.SCAN_CYCLES(SCAN)) amcs_sequencer_inst (
        .i_core_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
        .i_external_input_three(external_input_three), .i_encoder_index(enc_index),
        .o_axis_position, .o_axis_speed, .o_axis_enable);
    amcs_servo_model amcs_servo_model_inst (.i_core_clk, .i_rst_b,
        .i_axis_position(o_axis_position), .o_encoder_index(enc_index),
        .o_index_position(idx_pos));
    // =================================================================
    // Shared tasks
    task automatic check32(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon transfer; held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_core_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        check32("bus answer", 32'h0, {31'h0, o_avs_waitrequest});
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic scans(input int n);
        repeat (n * SCAN) @(posedge i_core_clk);
    endtask
    // Bounded wait on speed (0), moving (1) or position (2)
    task automatic wait_on(input string nm, input logic [31:0] v, input int sel);
        logic [31:0] s;
        int n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
            s = (sel == 2) ? o_axis_position : o_axis_speed;
            if (sel == 1) s = {31'h0, s !== 32'h0};
        end while (s !== v && n < 3000);
        check32(nm, v, s);
    endtask
    task automatic poll(input string nm, input logic [5:0] a, input int b, input logic v);
        int n = 0;
        do begin
            rd(a);
            n++;
        end while (q[b] !== v && n < 300);
        check32(nm, {31'h0, v}, {31'h0, q[b]});
    endtask
    task automatic pulse();
        @(posedge i_core_clk);
        external_input_three <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        external_input_three <= 1'b0;
        scans(2);
    endtask
    // =================================================================
    // Scenarios
    task automatic t_regs();
        rd(6'h20);
        check32("width reset", 32'h0000000a, q);
        rd(6'h28);
        check32("accel reset", 32'h00000010, q);
        rd(6'h02);
        check32("unmapped read", 32'h0, q);
        wr(6'h00, 32'h00000004);
        wr(6'h04, 32'h00000001);
        wr(6'h10, 32'h00000008);
        scans(2);
        check32("servo on", 32'h1, {31'h0, o_axis_enable});
    endtask
    task automatic t_feed();
        wr(6'h08, 32'h7);
        wait_on("feed speed", 32'h8, 0);
        rd(6'h34);
        check32("feed response", 32'h7, q);
        p0 = o_axis_position;
        wr(6'h10, 32'h14);
        wait_on("new speed", 32'h14, 0);
        check32("endless", 32'h1, {31'h0, o_axis_position > p0});
        wr(6'h0c, 32'h1);
        scans(4);
        check32("no hold", 32'h14, o_axis_speed);
        wr(6'h0c, 32'h0);
        wr(6'h08, 32'h0);
        wait_on("feed stop", 32'h0, 0);
        p0 = o_axis_position;
        scans(2);
        check32("feed stopped", p0, o_axis_position);
    endtask
    task automatic t_step();
        p0 = o_axis_position;
        wr(6'h18, 32'h28);
        wr(6'h1c, p0 + 32'h28);
        wr(6'h08, 32'h8);
        scans(3);
        wr(6'h18, 32'h3e8);
        poll("step in place", 6'h2c, 13, 1'b1);
        check32("step length", p0 + 32'h28, o_axis_position);
        poll("step released", 6'h30, 0, 1'b0);
        wr(6'h08, 32'h0);
        scans(2);
        p0 = o_axis_position;
        wr(6'h1c, p0 + 32'h3e8);
        wr(6'h08, 32'h8);
        wait_on("step moving", 32'h1, 1);
        wr(6'h0c, 32'h1);
        poll("hold done", 6'h30, 1, 1'b1);
        wait_on("held", 32'h0, 0);
        wr(6'h0c, 32'h0);
        wait_on("resumed", 32'h1, 1);
        wr(6'h0c, 32'h2);
        wait_on("aborted", 32'h0, 0);
        wr(6'h0c, 32'h0);
        p0 = o_axis_position;
        scans(4);
        check32("stays stopped", p0, o_axis_position);
    endtask
    task automatic t_capture();
        wr(6'h08, 32'h0);
        scans(2);
        p0 = o_axis_position;
        wr(6'h24, 32'h0);
        wr(6'h1c, p0);
        wr(6'h08, 32'h5);
        scans(2);
        pulse();
        rd(6'h3c);
        check32("captured", p0, q);
        rd(6'h30);
        check32("capture flag", 32'h1, {31'h0, q[4]});
        wr(6'h1c, p0 + 32'h1);
        pulse();
        rd(6'h3c);
        check32("no recapture", p0, q);
        wr(6'h08, 32'h0);
        wr(6'h24, 32'h1);
        scans(2);
        p0 = {o_axis_position[31:8] + 24'h1, 8'h08};
        wr(6'h1c, p0);
        wr(6'h08, 32'h5);
        wait_on("followed", p0, 2);
        rd(6'h3c);
        check32("index capture", idx_pos, q);
    endtask
    // =================================================================
    // Verdict, clock, watchdog and main sequence
    task automatic final_report();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // Scenarios need under 20000 cycles
    initial begin
        repeat (60000) @(posedge i_core_clk);
        err_count++;
        $display("unexpected watchdog expected done seen hang");
        final_report();
    end
    initial begin
        i_rst_b = 1'b0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 6'h0;
        i_avs_writedata = 32'h0;
        external_input_three = 1'b0;
        repeat (16) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        t_regs();
        t_feed();
        t_step();
        t_capture();
        final_report();
    end
endmodule
